// File: shared/dtid_pkg.sv
package dtid_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned DEBOUNCE_US      = 10;
  localparam int unsigned DEBOUNCE_CYCLES  = DEBOUNCE_US * CLK_MHZ;
  localparam int unsigned DEB_CNT_W        = 12;
  localparam int unsigned RAMP_TICK_US     = 1000;
  localparam int unsigned RAMP_TICK_CYCLES = RAMP_TICK_US * CLK_MHZ;

  // ****************************************
  // Widths
  // ****************************************
  localparam int unsigned NUM_TERM = 5;
  localparam int unsigned SEL_W    = 5;
  localparam int unsigned RATE_W   = 14;
  localparam int unsigned FREQ_W   = 16;
  localparam int unsigned SP_W     = 27;

  // Setpoint is kept in units of 0.00001 Hz so that a rate in 0.01 Hz/s adds exactly once per ms.
  localparam logic [SP_W-1:0] SP_RESET = 27'h0000000;
  localparam logic [SP_W-1:0] SP_MAX   = 27'h3938700;

  // ****************************************
  // Terminal function codes
  // ****************************************
  localparam logic [SEL_W-1:0] FN_NONE     = 5'h00;
  localparam logic [SEL_W-1:0] FN_RUN_FWD  = 5'h01;
  localparam logic [SEL_W-1:0] FN_RUN_REV  = 5'h02;
  localparam logic [SEL_W-1:0] FN_RESET    = 5'h03;
  localparam logic [SEL_W-1:0] FN_JOG_FWD  = 5'h04;
  localparam logic [SEL_W-1:0] FN_JOG_REV  = 5'h05;
  localparam logic [SEL_W-1:0] FN_PRESET0  = 5'h06;
  localparam logic [SEL_W-1:0] FN_ACC0     = 5'h0A;
  localparam logic [SEL_W-1:0] FN_ACC1     = 5'h0B;
  localparam logic [SEL_W-1:0] FN_FLT_NO   = 5'h0C;
  localparam logic [SEL_W-1:0] FN_FLT_NC   = 5'h0D;
  localparam logic [SEL_W-1:0] FN_UP       = 5'h0E;
  localparam logic [SEL_W-1:0] FN_DOWN     = 5'h0F;
  localparam logic [SEL_W-1:0] FN_COAST    = 5'h10;
  localparam logic [SEL_W-1:0] FN_3WIRE    = 5'h11;
  localparam logic [SEL_W-1:0] FN_REF_SW   = 5'h12;
  localparam logic [SEL_W-1:0] FN_TRAVERSE = 5'h14;
  localparam logic [SEL_W-1:0] FN_DC_BRAKE = 5'h15;
  localparam logic [SEL_W-1:0] FN_ESTOP    = 5'h1E;
  localparam logic [SEL_W-1:0] FN_MAX      = 5'h1E;

  // ****************************************
  // Wiring schemes, reference modes, channels
  // ****************************************
  localparam logic [1:0] WIRE_2A = 2'h0;
  localparam logic [1:0] WIRE_2B = 2'h1;
  localparam logic [1:0] WIRE_3A = 2'h2;
  localparam logic [1:0] WIRE_3B = 2'h3;

  localparam logic [2:0] REFM_POT     = 3'h4;
  localparam logic [2:0] REFM_POT_ADD = 3'h5;
  localparam logic [2:0] REFM_POT_SUB = 3'h6;

  localparam logic [1:0] CH_MAIN    = 2'h0;
  localparam logic [1:0] CH_POT     = 2'h1;
  localparam logic [1:0] CH_POT_ADD = 2'h2;
  localparam logic [1:0] CH_POT_SUB = 2'h3;

  localparam logic [1:0] ACC_SET1 = 2'h0;

  typedef enum logic [1:0] {
    RUN_STOP,
    RUN_FWD,
    RUN_REV
  } dtid_run_e;

endpackage : dtid_pkg

// File: hw/dtid_debounce.sv
`timescale 1ns/10ps
module dtid_debounce (
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  input  wire logic i_pin,
  output logic      o_sync,
  output logic      o_level
);
  import dtid_pkg::*;

  logic                 meta;
  logic [DEB_CNT_W-1:0] cnt;
  wire                  differs = (o_sync != o_level);

  // Two flip-flops bring the pin into the clock domain; only the second one is read.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta   <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta   <= i_pin;
      o_sync <= meta;
    end
  end

  // The level changes only after the synced pin stood still for the whole window, so contact bounce never reaches o_level or
  // the functions decoded from it; the price is a fixed latency of one window on every change.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt     <= '0;
      o_level <= 1'b0;
    end else if (!differs) begin
      cnt <= '0;
    end else if (cnt == DEB_CNT_W'(DEBOUNCE_CYCLES - 1)) begin
      cnt     <= '0;
      o_level <= o_sync;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

endmodule : dtid_debounce

// File: hw/dtid_updown.sv
`timescale 1ns/10ps
module dtid_updown #(
  parameter int unsigned TICK_CYCLES = dtid_pkg::RAMP_TICK_CYCLES
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_reset_n,
  input  wire logic                      i_up,
  input  wire logic                      i_down,
  input  wire logic [dtid_pkg::RATE_W-1:0] i_rate,
  input  wire logic                      i_load,
  input  wire logic [dtid_pkg::SP_W-1:0]   i_load_value,
  output logic      [dtid_pkg::SP_W-1:0]   o_setpoint
);
  import dtid_pkg::*;

  logic [31:0]   tick_cnt;
  wire           tick      = (tick_cnt == TICK_CYCLES - 1);
  wire           ramp_up   = i_up & ~i_down;
  wire           ramp_down = i_down & ~i_up;
  wire [SP_W:0]  sum       = {1'b0, o_setpoint} + {{(SP_W + 1 - RATE_W){1'b0}}, i_rate};
  wire [SP_W-1:0] rate_ext = {{(SP_W - RATE_W){1'b0}}, i_rate};
  wire [SP_W-1:0] next_up  = (sum > {1'b0, SP_MAX}) ? SP_MAX : sum[SP_W-1:0];
  wire [SP_W-1:0] next_dn  = (o_setpoint > rate_ext) ? (o_setpoint - rate_ext) : SP_RESET;

  // Millisecond tick for the ramp.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick ? '0 : tick_cnt + 32'h00000001;
    end
  end

  // Exactly one of up or down ramps; neither or both hold the value. A load from the core wins.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_setpoint <= SP_RESET;
    end else if (i_load) begin
      o_setpoint <= (i_load_value > SP_MAX) ? SP_MAX : i_load_value;
    end else if (tick && ramp_up) begin
      o_setpoint <= next_up;
    end else if (tick && ramp_down) begin
      o_setpoint <= next_dn;
    end
  end

endmodule : dtid_updown

// File: hw/dtid_input_decoder.sv
// What this block does
// - Scheme 0: exactly one of fwd/rev runs.
// - Scheme 1: fwd enables run, rev sets direction.
// - Three-wire: stop opens to stop, runs on edges.
// - Three-wire without terminal 3-5 assignment faults.
// - Five selectors, codes 0-30, zero repeatable.
// - Terminal five code 0 means pulse input.
// - Terminal mode: codes 1-2 run, 4-5 jog.
// - Code 3 rising edge clears pending fault.
// - Codes 6-9 pick one of fifteen presets.
// - Codes 10-11 pick ramp set, default one.
// - Codes 12/13 raise external fault, not stopping.
// - Up/down ramp setpoint; neither or both hold.
// - Code 16 active cuts output, motor coasts.
// - Code 18 switches reference channel in modes 4-6.
// - Code 20 enables manual-start traverse.
// - Code 21 brakes while active once decel stop falls below start frequency.
// - Code 30 active gives emergency coast stop.
`timescale 1ns/10ps
module dtid_input_decoder #(
  parameter int unsigned RAMP_TICK = dtid_pkg::RAMP_TICK_CYCLES
) (
  input  wire logic                          i_clk,
  input  wire logic                          i_reset_n,
  input  wire logic [dtid_pkg::NUM_TERM-1:0] i_programmable_inputs,
  input  wire logic [1:0]                    i_wiring_scheme_select,
  input  wire logic [dtid_pkg::SEL_W-1:0]    i_func_sel_1,
  input  wire logic [dtid_pkg::SEL_W-1:0]    i_func_sel_2,
  input  wire logic [dtid_pkg::SEL_W-1:0]    i_func_sel_3,
  input  wire logic [dtid_pkg::SEL_W-1:0]    i_func_sel_4,
  input  wire logic [dtid_pkg::SEL_W-1:0]    i_func_sel_5,
  input  wire logic                          i_command_source_select,
  input  wire logic [2:0]                    i_reference_mode_select,
  input  wire logic                          i_simple_program_mode,
  input  wire logic                          i_traverse_manual_start,
  input  wire logic                          i_decel_to_stop,
  input  wire logic                          i_normal_stop,
  input  wire logic [dtid_pkg::FREQ_W-1:0]   i_running_freq,
  input  wire logic [dtid_pkg::FREQ_W-1:0]   i_dc_brake_start_freq,
  input  wire logic                          i_panel_reset,
  input  wire logic [dtid_pkg::RATE_W-1:0]   i_updown_ramp_rate,
  input  wire logic                          i_setpoint_load,
  input  wire logic [dtid_pkg::SP_W-1:0]     i_setpoint_value,
  output logic                               o_run_forward,
  output logic                               o_run_reverse,
  output logic                               o_jog_forward_function,
  output logic                               o_jog_backward_function,
  output logic                               o_fault_reset,
  output logic [3:0]                         o_preset_select,
  output logic [1:0]                         o_accel_set,
  output logic                               o_accel_set_valid,
  output logic                               o_external_fault_code,
  output logic                               o_setting_fault_code,
  output logic                               o_coast_stop_function,
  output logic                               o_emergency_stop,
  output logic [1:0]                         o_ref_channel,
  output logic                               o_traverse_enable,
  output logic                               o_dc_brake,
  output logic                               o_dc_brake_time_ignored,
  output logic                               o_pulse_input_enable,
  output logic                               o_pulse_input,
  output logic [dtid_pkg::SP_W-1:0]          o_freq_setpoint
);
  import dtid_pkg::*;

  // ****************************************
  // Decoding helpers
  // ****************************************

  // True when any terminal carries the code and is on.
  function automatic logic any_on(input logic [NUM_TERM-1:0] lv, input logic [NUM_TERM*SEL_W-1:0] sels,
                                  input logic [SEL_W-1:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_TERM; i++) begin
      if (sels[i*SEL_W +: SEL_W] == code && lv[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : any_on

  // ****************************************
  // Input conditioning
  // ****************************************
  logic [NUM_TERM-1:0]       term_sync;
  logic [NUM_TERM-1:0]       term_level;
  logic [NUM_TERM-1:0]       term_prev;
  wire  [NUM_TERM-1:0]       term_rise = term_level & ~term_prev;
  wire  [NUM_TERM-1:0]       all_ones  = '1;
  wire  [NUM_TERM*SEL_W-1:0] sel_bus   = {i_func_sel_5, i_func_sel_4, i_func_sel_3, i_func_sel_2, i_func_sel_1};

  genvar g;
  generate
    for (g = 0; g < NUM_TERM; g++) begin : g_term
      dtid_debounce u_deb (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_pin     (i_programmable_inputs[g]),
        .o_sync    (term_sync[g]),
        .o_level   (term_level[g])
      );
    end
  endgenerate

  // Previous debounced level for edge detection.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      term_prev <= '0;
    end else begin
      term_prev <= term_level;
    end
  end

  // ****************************************
  // Function decode
  // ****************************************
  wire three_wire    = (i_wiring_scheme_select == WIRE_3A) || (i_wiring_scheme_select == WIRE_3B);
  wire term_mode     = i_command_source_select;
  wire fwd_on        = any_on(term_level, sel_bus, FN_RUN_FWD);
  wire rev_on        = any_on(term_level, sel_bus, FN_RUN_REV);
  wire fwd_rise      = any_on(term_rise, sel_bus, FN_RUN_FWD);
  wire rev_rise      = any_on(term_rise, sel_bus, FN_RUN_REV);
  wire coast_on      = any_on(term_level, sel_bus, FN_COAST);
  wire estop_on      = any_on(term_level, sel_bus, FN_ESTOP);
  // A normally closed stop contact that is open reads low, so it stops the motor.
  wire stop_closed   = any_on(term_level, sel_bus, FN_3WIRE);
  wire three_wire_ok = any_on(5'h1C, sel_bus, FN_3WIRE);
  wire sel_too_big   = (i_func_sel_1 > FN_MAX) || (i_func_sel_2 > FN_MAX) || (i_func_sel_3 > FN_MAX) ||
                       (i_func_sel_4 > FN_MAX) || (i_func_sel_5 > FN_MAX);
  wire acc0_used     = any_on(all_ones, sel_bus, FN_ACC0);
  wire acc1_used     = any_on(all_ones, sel_bus, FN_ACC1);
  wire nc_used       = any_on(all_ones, sel_bus, FN_FLT_NC);
  wire nc_ok         = any_on(term_level, sel_bus, FN_FLT_NC);
  wire brake_on      = any_on(term_level, sel_bus, FN_DC_BRAKE);
  wire ref_mode_sw   = (i_reference_mode_select == REFM_POT) || (i_reference_mode_select == REFM_POT_ADD) ||
                       (i_reference_mode_select == REFM_POT_SUB);
  wire [3:0] preset_code;

  generate
    for (g = 0; g < 4; g++) begin : g_preset
      assign preset_code[g] = any_on(term_level, sel_bus, SEL_W'(FN_PRESET0 + g));
    end
  endgenerate

  wire fault_seen = ~i_normal_stop & (any_on(term_level, sel_bus, FN_FLT_NO) | (nc_used & ~nc_ok));

  wire reset_rise = any_on(term_rise, sel_bus, FN_RESET);

  wire [1:0] next_ref_channel = (!ref_mode_sw || !any_on(term_level, sel_bus, FN_REF_SW)) ? CH_MAIN :
                                (i_reference_mode_select == REFM_POT)     ? CH_POT :
                                (i_reference_mode_select == REFM_POT_ADD) ? CH_POT_ADD : CH_POT_SUB;

  wire next_acc_valid = acc0_used | acc1_used | ~i_simple_program_mode;
  wire [1:0] next_acc = (acc0_used | acc1_used) ?
                        {any_on(term_level, sel_bus, FN_ACC1), any_on(term_level, sel_bus, FN_ACC0)} : ACC_SET1;

  wire brake_window = i_decel_to_stop & (i_running_freq < i_dc_brake_start_freq);

  // ****************************************
  // Run command decode
  // ****************************************
  dtid_run_e run_state;
  dtid_run_e next_run_state;
  logic      next_two_fwd;
  logic      next_two_rev;

  always_comb begin
    next_two_fwd = 1'b0;
    next_two_rev = 1'b0;
    unique case (i_wiring_scheme_select)
      WIRE_2A: begin
        next_two_fwd = fwd_on & ~rev_on;
        next_two_rev = rev_on & ~fwd_on;
      end
      WIRE_2B: begin
        next_two_fwd = fwd_on & ~rev_on;
        next_two_rev = fwd_on & rev_on;
      end
      WIRE_3A, WIRE_3B: begin
        next_two_fwd = 1'b0;
        next_two_rev = 1'b0;
      end
    endcase
  end

  // three-wire latch
  // Start edges are caught on debounced levels, so one press gives one start even with a bouncing button.
  always_comb begin
    next_run_state = run_state;
    if (!three_wire || !stop_closed || coast_on || estop_on || !term_mode) begin
      next_run_state = RUN_STOP;
    end else if (i_wiring_scheme_select == WIRE_3A) begin
      if (fwd_rise) begin
        next_run_state = RUN_FWD;
      end else if (rev_rise) begin
        next_run_state = RUN_REV;
      end
    end else begin
      // Here the run terminal starts and the reverse terminal is a held direction switch.
      if (fwd_rise || run_state != RUN_STOP) begin
        next_run_state = rev_on ? RUN_REV : RUN_FWD;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      run_state <= RUN_STOP;
    end else begin
      run_state <= next_run_state;
    end
  end

  wire halt       = coast_on | estop_on;
  wire next_fwd   = ~halt & term_mode & (three_wire ? (next_run_state == RUN_FWD) : next_two_fwd);
  wire next_rev   = ~halt & term_mode & (three_wire ? (next_run_state == RUN_REV) : next_two_rev);

  // ****************************************
  // Registered outputs
  // ****************************************

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_run_forward           <= 1'b0;
      o_run_reverse           <= 1'b0;
      o_jog_forward_function  <= 1'b0;
      o_jog_backward_function <= 1'b0;
    end else begin
      o_run_forward           <= next_fwd;
      o_run_reverse           <= next_rev;
      o_jog_forward_function  <= ~halt & term_mode & any_on(term_level, sel_bus, FN_JOG_FWD);
      o_jog_backward_function <= ~halt & term_mode & any_on(term_level, sel_bus, FN_JOG_REV);
    end
  end

  // sticky external fault
  // A new fault in the same cycle as a reset stays set, so no event is lost.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_external_fault_code <= 1'b0;
      o_fault_reset         <= 1'b0;
    end else begin
      o_fault_reset <= reset_rise;
      if (fault_seen) begin
        o_external_fault_code <= 1'b1;
      end else if (reset_rise || i_panel_reset) begin
        o_external_fault_code <= 1'b0;
      end
    end
  end

  // setting fault
  // The check is continuous, so the fault clears as soon as the configuration becomes legal.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_setting_fault_code <= 1'b0;
    end else begin
      o_setting_fault_code <= (three_wire & ~three_wire_ok) | sel_too_big;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_coast_stop_function <= 1'b0;
      o_emergency_stop      <= 1'b0;
    end else begin
      o_coast_stop_function <= coast_on;
      o_emergency_stop      <= estop_on;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_preset_select   <= 4'h0;
      o_accel_set       <= ACC_SET1;
      o_accel_set_valid <= 1'b1;
      o_ref_channel     <= CH_MAIN;
      o_traverse_enable <= 1'b0;
    end else begin
      o_preset_select   <= preset_code;
      o_accel_set       <= next_acc;
      o_accel_set_valid <= next_acc_valid;
      o_ref_channel     <= next_ref_channel;
      o_traverse_enable <= i_traverse_manual_start & any_on(term_level, sel_bus, FN_TRAVERSE);
    end
  end

  // terminal held braking
  // Once engaged the brake follows only the terminal, since a fixed braking time no longer applies.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_dc_brake              <= 1'b0;
      o_dc_brake_time_ignored <= 1'b0;
    end else begin
      o_dc_brake_time_ignored <= any_on(all_ones, sel_bus, FN_DC_BRAKE);
      if (!brake_on) begin
        o_dc_brake <= 1'b0;
      end else if (brake_window) begin
        o_dc_brake <= 1'b1;
      end
    end
  end

  // pulse input on terminal five
  // The pulse path skips the debouncer, which would swallow a fast frequency input.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pulse_input_enable <= 1'b0;
      o_pulse_input        <= 1'b0;
    end else begin
      o_pulse_input_enable <= (i_func_sel_5 == FN_NONE);
      o_pulse_input        <= (i_func_sel_5 == FN_NONE) & term_sync[NUM_TERM-1];
    end
  end

  // ****************************************
  // Setpoint ramp
  // ****************************************

  dtid_updown #(
    .TICK_CYCLES (RAMP_TICK)
  ) u_updown (
    .i_clk        (i_clk),
    .i_reset_n    (i_reset_n),
    .i_up         (any_on(term_level, sel_bus, FN_UP)),
    .i_down       (any_on(term_level, sel_bus, FN_DOWN)),
    .i_rate       (i_updown_ramp_rate),
    .i_load       (i_setpoint_load),
    .i_load_value (i_setpoint_value),
    .o_setpoint   (o_freq_setpoint)
  );

endmodule : dtid_input_decoder

// File: bench/dtid_checker.sv
`timescale 1ns/10ps
module dtid_checker
  import dtid_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic [1:0]  i_wiring_scheme_select,
  input wire logic [4:0]  i_func_sel_3,
  input wire logic [4:0]  i_func_sel_4,
  input wire logic [4:0]  i_func_sel_5,
  input wire logic [2:0]  i_reference_mode_select,
  input wire logic        i_simple_program_mode,
  input wire logic        i_decel_to_stop,
  input wire logic [15:0] i_running_freq,
  input wire logic [15:0] i_dc_brake_start_freq,
  input wire logic        o_run_forward,
  input wire logic        o_run_reverse,
  input wire logic        o_fault_reset,
  input wire logic        o_accel_set_valid,
  input wire logic        o_setting_fault_code,
  input wire logic        o_coast_stop_function,
  input wire logic        o_emergency_stop,
  input wire logic [1:0]  o_ref_channel,
  input wire logic        o_dc_brake,
  input wire logic        o_pulse_input_enable
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  logic alive;
  // Masks the first edge after reset, where $past still sees reset values.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) alive <= 1'b0;
    else alive <= 1'b1;
  end
  sequence s_no_stop_term;
    alive && i_wiring_scheme_select[1] && i_func_sel_3 != FN_3WIRE && i_func_sel_4 != FN_3WIRE && i_func_sel_5 != FN_3WIRE;
  endsequence
  run_excl_a:
    assert property (!(o_run_forward && o_run_reverse)) else $error("Both run directions high.");
  coast_holds_a:
    assert property (o_coast_stop_function && $past(o_coast_stop_function) |-> !o_run_forward && !o_run_reverse) else $error("Run during coast stop.");
  estop_holds_a:
    assert property (o_emergency_stop && $past(o_emergency_stop) |-> !o_run_forward && !o_run_reverse) else $error("Run during emergency stop.");
  reset_pulse_a:
    assert property (o_fault_reset |=> !o_fault_reset) else $error("Fault reset pulse too long.");
  setting_fault_a:
    assert property (s_no_stop_term |=> o_setting_fault_code) else $error("Missing setting fault.");
  pulse_enable_a:
    assert property (alive |-> o_pulse_input_enable == ($past(i_func_sel_5) == FN_NONE)) else $error("Pulse enable wrong.");
  brake_cause_a:
    assert property (alive && $rose(o_dc_brake) |-> $past(i_decel_to_stop) && $past(i_running_freq) < $past(i_dc_brake_start_freq)) else $error("Brake without cause.");
  accel_valid_a:
    assert property (alive && !$past(i_simple_program_mode) |-> o_accel_set_valid) else $error("Accel set invalid.");
  ref_main_a:
    assert property (alive && $past(i_reference_mode_select) < REFM_POT |-> o_ref_channel == CH_MAIN) else $error("Channel not main.");
endmodule : dtid_checker

// File: bench/dtid_contacts.sv
`timescale 1ns/10ps
// Operator buttons and contacts; open contacts fall to the pull-down, so a released line reads 0.
module dtid_contacts (
  input  wire logic       i_clk,
  input  wire logic [4:0] i_press,
  output logic      [4:0] o_terminals
);
  always_ff @(posedge i_clk) begin
    o_terminals <= i_press;
  end
endmodule : dtid_contacts

// File: bench/testbench.sv
`timescale 1ns/10ps
module testbench;
  import dtid_pkg::*;
  // ****************************************
  // Stimulus and checks
  // ****************************************
  logic i_clk, i_reset_n, src, simple, trav, decel, nstop, panel, ld;
  logic [4:0] press, terms;
  logic [4:0] sel [1:5];
  logic [1:0] scheme;
  logic [2:0] refm;
  logic [13:0] rate;
  logic [26:0] ldv, sp0;
  logic fw, rv, jf, jb, frst, extf, setf, cst, es, trv, dcb, pen, dti, pin;
  logic [3:0] pre;
  logic [1:0] acc, refc;
  logic accv;
  logic [26:0] sp;
  int error_cnt, tests_run, k;
  logic [4:0] codes [6] = '{5'h04, 5'h05, 5'h14, 5'h15, 5'h1E, 5'h10};
  logic [5:0] exps [6] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01};
  dtid_contacts u_contacts (.i_clk(i_clk), .i_press(press), .o_terminals(terms));
  dtid_input_decoder #(.RAMP_TICK(10)) u_dut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_programmable_inputs(terms), .i_wiring_scheme_select(scheme),
    .i_func_sel_1(sel[1]), .i_func_sel_2(sel[2]), .i_func_sel_3(sel[3]), .i_func_sel_4(sel[4]),
    .i_func_sel_5(sel[5]), .i_command_source_select(src), .i_reference_mode_select(refm),
    .i_simple_program_mode(simple), .i_traverse_manual_start(trav), .i_decel_to_stop(decel),
    .i_normal_stop(nstop), .i_running_freq(16'h0010), .i_dc_brake_start_freq(16'h0100), .i_panel_reset(panel),
    .i_updown_ramp_rate(rate), .i_setpoint_load(ld), .i_setpoint_value(ldv), .o_run_forward(fw),
    .o_run_reverse(rv), .o_jog_forward_function(jf), .o_jog_backward_function(jb), .o_fault_reset(frst),
    .o_preset_select(pre), .o_accel_set(acc), .o_accel_set_valid(accv), .o_external_fault_code(extf),
    .o_setting_fault_code(setf), .o_coast_stop_function(cst), .o_emergency_stop(es), .o_ref_channel(refc),
    .o_traverse_enable(trv), .o_dc_brake(dcb), .o_dc_brake_time_ignored(dti), .o_pulse_input_enable(pen),
    .o_pulse_input(pin), .o_freq_setpoint(sp));
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
  endtask : step
  // Debounce plus sync and contact register settle in about 2504 cycles, just inside 2510.
  task automatic term(input logic [4:0] v);
    @(posedge i_clk) press <= v;
    step(2510);
  endtask : term
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  initial begin
    i_reset_n = 0; press = 0; scheme = 0; src = 1; refm = 0; simple = 0; trav = 1; decel = 1;
    nstop = 0; panel = 0; rate = 14'h0064; ld = 0; ldv = 0;
    sel[1] = 5'h01; sel[2] = 5'h02; sel[3] = 5'h10; sel[4] = 5'h03; sel[5] = 5'h0C;
    step(6);
    i_reset_n <= 1'b1;
    for (k = 0; k < 4; k++) begin
      scheme <= WIRE_2A;
      term(k[4:0]);
      chk({fw, rv}, {k == 1, k == 2});
      @(posedge i_clk) scheme <= WIRE_2B;
      step(3);
      chk({fw, rv}, {k == 1, k == 3});
    end
    term(5'h05);
    chk({fw, cst}, 2'h1);
    term(5'h10);
    term(5'h00);
    chk(extf, 1'b1);
    @(posedge i_clk) press <= 5'h08;
    for (k = 0; k < 2600 && frst !== 1'b1; k++) @(posedge i_clk);
    if (k == 2600) begin
      error_cnt++;
      print_verdict();
    end
    step(3);
    chk(extf, 1'b0);
    nstop <= 1'b1;
    term(5'h10);
    chk(extf, 1'b0);
    term(5'h00);
    nstop <= 1'b0;
    $display("Test two-wire and faults done");
    @(posedge i_clk) scheme <= WIRE_3A;
    step(3);
    chk(setf, 1'b1);
    @(posedge i_clk) sel[3] <= FN_3WIRE;
    step(3);
    chk(setf, 1'b0);
    term(5'h04);
    term(5'h05);
    term(5'h04);
    chk({fw, rv}, 2'h2);
    term(5'h00);
    chk(fw, 1'b0);
    $display("Test three-wire done");
    scheme <= WIRE_2A; sel[1] <= 5'h06; sel[2] <= 5'h07; sel[3] <= 5'h08; sel[4] <= 5'h09; sel[5] <= 5'h00;
    term(5'h1A);
    chk({pre, pen, pin}, 6'h2B);
    @(posedge i_clk) begin
      sel[1] <= FN_ACC0; sel[2] <= FN_ACC1; refm <= REFM_POT_ADD; sel[3] <= 5'h00; sel[4] <= 5'h00;
    end
    step(3);
    chk({acc, accv}, 3'h5);
    @(posedge i_clk) sel[2] <= FN_REF_SW;
    step(3);
    chk(refc, CH_POT_ADD);
    @(posedge i_clk) begin
      sel[1] <= 5'h00; sel[2] <= 5'h00; simple <= 1'b1;
    end
    step(3);
    chk(accv, 1'b0);
    term(5'h01);
    for (k = 0; k < 6; k++) begin
      @(posedge i_clk) sel[1] <= codes[k];
      step(3);
      chk({jf, jb, trv, dcb, es, cst}, exps[k]);
    end
    @(posedge i_clk) begin
      sel[1] <= FN_DC_BRAKE; decel <= 1'b0;
    end
    step(3);
    chk({dcb, dti}, 2'h1);
    $display("Test single functions done");
    @(posedge i_clk) begin
      sel[1] <= FN_UP; sel[2] <= FN_DOWN; ld <= 1'b1; ldv <= 27'h00003E8;
    end
    @(posedge i_clk) ld <= 1'b0;
    step(2);
    sp0 = sp;
    step(10);
    chk(sp - sp0, 27'h0000064);
    term(5'h03);
    sp0 = sp;
    step(10);
    chk(sp, sp0);
    @(posedge i_clk) sel[5] <= FN_FLT_NC;
    step(3);
    chk(extf, 1'b1);
    $display("Test up/down done");
    print_verdict();
  end
endmodule : testbench
bind dtid_input_decoder dtid_checker u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_wiring_scheme_select(i_wiring_scheme_select), .i_func_sel_3(i_func_sel_3), .i_func_sel_4(i_func_sel_4),
  .i_func_sel_5(i_func_sel_5), .i_reference_mode_select(i_reference_mode_select),
  .i_simple_program_mode(i_simple_program_mode), .i_decel_to_stop(i_decel_to_stop),
  .i_running_freq(i_running_freq), .i_dc_brake_start_freq(i_dc_brake_start_freq),
  .o_run_forward(o_run_forward), .o_run_reverse(o_run_reverse), .o_fault_reset(o_fault_reset),
  .o_accel_set_valid(o_accel_set_valid), .o_setting_fault_code(o_setting_fault_code),
  .o_coast_stop_function(o_coast_stop_function), .o_emergency_stop(o_emergency_stop),
  .o_ref_channel(o_ref_channel), .o_dc_brake(o_dc_brake), .o_pulse_input_enable(o_pulse_input_enable));
